// file: logic/rcl_regs.vh
// Register map, field positions, reset values and timing counts of the run-command block
`ifndef RCL_REGS_VH
`define RCL_REGS_VH

`define RCL_CLK_MHZ 50
`define RCL_DEB_US 1000
`define RCL_DEB_CYC 20'd50000
`define RCL_FAST_MS 50
`define RCL_FAST_CYC 28'd2500000
`define RCL_FLASH_MS 2000
`define RCL_FLASH_CYC 28'd100000000
`define RCL_CONF_MS 3000
`define RCL_CONF_CYC 28'd150000000

`define RCL_OFF_CTRL 8'h00
`define RCL_OFF_STATUS 8'h04
`define RCL_OFF_ALMCLR 8'h08
`define RCL_OFF_EDIT 8'h0C
`define RCL_OFF_CUR 8'h10
`define RCL_OFF_SPD0 8'h20
`define RCL_OFF_ACC0 8'h30
`define RCL_OFF_DEC0 8'h40

`define RCL_CTRL_SRC_LSB 0
`define RCL_CTRL_LOCK 2
`define RCL_CTRL_POT 3
`define RCL_SRC_PANEL 2'h0
`define RCL_SRC_EXTPNL 2'h1
`define RCL_SRC_EXTONLY 2'h2

`define RCL_ST_RUN 0
`define RCL_ST_DIR 1
`define RCL_ST_PDIS 2
`define RCL_ST_ALARM 3
`define RCL_ST_SET_LSB 4
`define RCL_ST_EDIT 6
`define RCL_ST_CONF 7
`define RCL_ST_HSTOP 8

`define RCL_CTRL_RST 4'h8
`define RCL_SPD_RST 16'h0000
`define RCL_RAMP_RST 16'h0100
`define RCL_SPD_MAX 16'h0FA0
`define RCL_FAST_STEP 16'h000A

`endif

// file: logic/rcl_sync.v
// Two-flop synchroniser and debounce filter for a group of pin inputs
`timescale 1ns/1ps
module rcl_sync #(
    parameter W = 9,
    parameter [19:0] DEB_CYC = 20'd50000
) (
    input wire core_clk_in,
    input wire rst_in,
    input wire [W-1:0] raw_in,
    output wire [W-1:0] clean_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_r;
            reg s2_r;
            reg q_r;
            reg [19:0] cnt_r;
            always @(posedge core_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    q_r <= 1'b0;
                    cnt_r <= 20'h00000;
                end else begin
                    s1_r <= raw_in[i];
                    s2_r <= s1_r;
                    // Accept a new level only after it stood for the full debounce time
                    if (s2_r == q_r) begin
                        cnt_r <= 20'h00000;
                    end else if (cnt_r >= DEB_CYC - 20'd1) begin
                        q_r <= s2_r;
                        cnt_r <= 20'h00000;
                    end else begin
                        cnt_r <= cnt_r + 20'd1;
                    end
                end
            end
            assign clean_out[i] = q_r;
        end
    endgenerate
endmodule // rcl_sync

// file: logic/rcl_run_ctrl.v
// Run-command, direction, dial editing and data-set ramp control with APB registers
`timescale 1ns/1ps
`include "rcl_regs.vh"

module rcl_run_ctrl #(
    parameter [19:0] DEB_CYC = `RCL_DEB_CYC,
    parameter [27:0] FAST_CYC = `RCL_FAST_CYC,
    parameter [27:0] FLASH_CYC = `RCL_FLASH_CYC,
    parameter [27:0] CONF_CYC = `RCL_CONF_CYC
) (
    input wire core_clk_in,
    input wire rst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    input wire run_switch_in,
    input wire dir_switch_in,
    input wire dial_a_in,
    input wire dial_b_in,
    input wire dial_push_in,
    input wire forward_run_input_in,
    input wire reverse_run_input_in,
    input wire data_select_low_in,
    input wire data_select_high_in,
    input wire [7:0] ramp_pot_in,
    output reg [15:0] motor_speed_out,
    output reg motor_dir_out,
    output reg motor_run_out,
    output reg hard_stop_out,
    output reg edit_blink_out,
    output reg confirm_blink_out,
    output reg panel_disabled_out,
    output reg poweron_run_alarm_out,
    output reg [1:0] set_sel_out
);
    wire [8:0] clean;
    // Input synchronising and debouncing
    rcl_sync #(
        .W(9),
        .DEB_CYC(DEB_CYC)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .raw_in({dial_b_in, dial_a_in, dial_push_in, data_select_high_in, data_select_low_in,
                 reverse_run_input_in, forward_run_input_in, dir_switch_in, run_switch_in}),
        .clean_out(clean)
    );
    wire run_sw = clean[0];
    wire dir_sw = clean[1];
    wire forward_run_input = clean[2];
    wire reverse_run_input = clean[3];
    wire [1:0] dsel = clean[5:4];
    wire push = clean[6];
    wire dial_a = clean[7];
    wire dial_b = clean[8];

    reg [3:0] ctrl_r;
    reg [15:0] spd_r [0:3];
    reg [15:0] acc_r [0:3];
    reg [15:0] dec_r [0:3];
    reg [15:0] edit_r;
    reg [15:0] cur_r;
    reg dir_r;
    reg edit_pend_r;
    reg alarm_r;
    reg [20:0] boot_cnt_r;
    reg booted_r;
    reg dial_a_q_r;
    reg push_q_r;
    reg dir_q_r;
    reg [27:0] gap_cnt_r;
    reg [27:0] flash_cnt_r;
    reg [27:0] conf_cnt_r;
    reg [19:0] ramp_cnt_r;

    wire [1:0] src = ctrl_r[`RCL_CTRL_SRC_LSB+1:`RCL_CTRL_SRC_LSB];
    wire ext_only = (src == `RCL_SRC_EXTONLY);
    wire ext_mode = (src == `RCL_SRC_EXTPNL) || ext_only;
    wire lock = ctrl_r[`RCL_CTRL_LOCK];

    // Panel events
    wire detent = dial_a & ~dial_a_q_r;
    wire cw = ~dial_b;
    wire press = push & ~push_q_r;
    wire dir_chg = dir_sw ^ dir_q_r;
    wire fast = (gap_cnt_r < FAST_CYC);

    // Run request and direction decision
    reg run_req;
    reg dir_req;
    reg both_on;
    reg [1:0] set_sel;
    always @* begin
        run_req = 1'b0;
        dir_req = dir_sw;
        both_on = 1'b0;
        set_sel = 2'h0;
        if (!ext_mode) begin
            run_req = run_sw;
        end else begin
            set_sel = dsel;
            both_on = forward_run_input & reverse_run_input;
            if (ext_only) begin
                run_req = forward_run_input ^ reverse_run_input;
                dir_req = reverse_run_input;
            end else begin
                run_req = run_sw & (forward_run_input ^ reverse_run_input);
                dir_req = reverse_run_input ? ~dir_sw : dir_sw;
            end
        end
        if (alarm_r || !booted_r) begin
            run_req = 1'b0;
        end
    end

    // Target speed from the selected data set, ramp period from ramp_pot_in when the RCL_CTRL_POT bit is set, else from the data set
    wire [15:0] sel_spd = spd_r[set_sel];
    wire going_up = run_req && (dir_req == dir_r) && (cur_r < sel_spd);
    wire [15:0] tgt = (run_req && (dir_req == dir_r)) ? sel_spd : 16'h0000;
    wire [15:0] ramp_val = ctrl_r[`RCL_CTRL_POT] ? {ramp_pot_in, 8'h00} :
                           (going_up ? acc_r[set_sel] : dec_r[set_sel]);
    wire [19:0] ramp_per = {ramp_val, 4'h0};

    // Dial step with clamping
    wire [15:0] step = fast ? `RCL_FAST_STEP : 16'h0001;
    reg [15:0] edit_nxt;
    always @* begin
        edit_nxt = edit_r;
        if (cw) begin
            if (edit_r > `RCL_SPD_MAX - step) begin
                edit_nxt = `RCL_SPD_MAX;
            end else begin
                edit_nxt = edit_r + step;
            end
        end else begin
            if (edit_r < step) begin
                edit_nxt = 16'h0000;
            end else begin
                edit_nxt = edit_r - step;
            end
        end
    end

    // APB decode
    wire setup = psel_in & ~penable_in;
    wire wr_en = psel_in & penable_in & pready_out & pwrite_in & ~pslverr_out;
    wire in_set = (paddr_in[7:4] == 4'h2) || (paddr_in[7:4] == 4'h3) || (paddr_in[7:4] == 4'h4);
    wire mapped = (paddr_in[1:0] == 2'h0) &&
                  (in_set ? (paddr_in[3:2] <= 2'h3) : (paddr_in <= `RCL_OFF_CUR));
    wire [1:0] idx = paddr_in[3:2];

    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        case (paddr_in[7:4])
            4'h0: begin
                case (paddr_in)
                    `RCL_OFF_CTRL: rd_mux = {28'h0000000, ctrl_r};
                    `RCL_OFF_STATUS: rd_mux = {23'h000000, hard_stop_out, confirm_blink_out,
                                               edit_pend_r, set_sel_out, alarm_r,
                                               panel_disabled_out, dir_r, motor_run_out};
                    `RCL_OFF_EDIT: rd_mux = {16'h0000, edit_r};
                    default: rd_mux = 32'h00000000;
                endcase
            end
            4'h1: rd_mux = {16'h0000, cur_r};
            4'h2: rd_mux = {16'h0000, spd_r[idx]};
            4'h3: rd_mux = {16'h0000, acc_r[idx]};
            4'h4: rd_mux = {16'h0000, dec_r[idx]};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_out <= 32'h00000000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            ctrl_r <= `RCL_CTRL_RST;
        end else begin
            pready_out <= setup;
            pslverr_out <= setup & ~mapped;
            prdata_out <= (setup && mapped && !pwrite_in) ? rd_mux : 32'h00000000;
            if (wr_en && paddr_in == `RCL_OFF_CTRL) begin
                ctrl_r <= (pwdata_in[1:0] == 2'h3) ? {pwdata_in[3:2], ctrl_r[1:0]} : pwdata_in[3:0];
            end
        end
    end

    // Per-set storage, set 0 also loaded by a dial commit
    wire commit = press & edit_pend_r & ~lock & ~ext_only;
    genvar s;
    generate
        for (s = 0; s < 4; s = s + 1) begin : g_set
            always @(posedge core_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    spd_r[s] <= `RCL_SPD_RST;
                    acc_r[s] <= `RCL_RAMP_RST;
                    dec_r[s] <= `RCL_RAMP_RST;
                end else begin
                    if (s == 0 && commit) begin
                        spd_r[s] <= edit_r;
                    end else if (wr_en && in_set && paddr_in[7:4] == 4'h2 && idx == s) begin
                        spd_r[s] <= pwdata_in[15:0];
                    end
                    if (wr_en && paddr_in[7:4] == 4'h3 && idx == s) begin
                        acc_r[s] <= pwdata_in[15:0];
                    end
                    if (wr_en && paddr_in[7:4] == 4'h4 && idx == s) begin
                        dec_r[s] <= pwdata_in[15:0];
                    end
                end
            end
        end
    endgenerate

    // Power-on check, dial editing and panel-disabled indication
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            boot_cnt_r <= 21'h000000;
            booted_r <= 1'b0;
            alarm_r <= 1'b0;
            dial_a_q_r <= 1'b0;
            push_q_r <= 1'b0;
            dir_q_r <= 1'b0;
            // Start as a long gap so the first detent after reset is a slow one
            gap_cnt_r <= FAST_CYC;
            flash_cnt_r <= 28'h0000000;
            conf_cnt_r <= 28'h0000000;
            edit_r <= `RCL_SPD_RST;
            edit_pend_r <= 1'b0;
        end else begin
            dial_a_q_r <= dial_a;
            push_q_r <= push;
            dir_q_r <= dir_sw;
            // Wait until the filtered inputs settle before judging the run switch
            if (!booted_r) begin
                boot_cnt_r <= boot_cnt_r + 21'd1;
                if (boot_cnt_r >= {1'b0, DEB_CYC} + 21'd4) begin
                    booted_r <= 1'b1;
                    alarm_r <= run_sw;
                end
            end else if (wr_en && paddr_in == `RCL_OFF_ALMCLR && pwdata_in[0] && !run_sw) begin
                alarm_r <= 1'b0;
            end
            if (detent) begin
                gap_cnt_r <= 28'h0000000;
            end else if (gap_cnt_r < FAST_CYC) begin
                gap_cnt_r <= gap_cnt_r + 28'd1;
            end
            if (!edit_pend_r) begin
                edit_r <= spd_r[0];
            end
            if (detent && !lock && !ext_only) begin
                edit_r <= edit_nxt;
                edit_pend_r <= 1'b1;
            end else if (commit) begin
                edit_pend_r <= 1'b0;
            end
            if (press && !edit_pend_r && cur_r == 16'h0000 && !ext_only) begin
                conf_cnt_r <= CONF_CYC;
            end else if (conf_cnt_r != 28'h0000000) begin
                conf_cnt_r <= conf_cnt_r - 28'd1;
            end
            if (ext_only && (dir_chg || detent || press)) begin
                flash_cnt_r <= FLASH_CYC;
            end else if (flash_cnt_r != 28'h0000000) begin
                flash_cnt_r <= flash_cnt_r - 28'd1;
            end
        end
    end

    // Speed ramp, direction and outputs
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cur_r <= 16'h0000;
            dir_r <= 1'b0;
            ramp_cnt_r <= 20'h00000;
            motor_speed_out <= 16'h0000;
            motor_dir_out <= 1'b0;
            motor_run_out <= 1'b0;
            hard_stop_out <= 1'b0;
            edit_blink_out <= 1'b0;
            confirm_blink_out <= 1'b0;
            panel_disabled_out <= 1'b0;
            poweron_run_alarm_out <= 1'b0;
            set_sel_out <= 2'h0;
        end else begin
            if (both_on) begin
                cur_r <= 16'h0000;
                ramp_cnt_r <= 20'h00000;
            end else if (cur_r == tgt) begin
                ramp_cnt_r <= 20'h00000;
                if (cur_r == 16'h0000 && run_req) begin
                    dir_r <= dir_req;
                end
            end else if (ramp_cnt_r >= ramp_per) begin
                ramp_cnt_r <= 20'h00000;
                cur_r <= (cur_r < tgt) ? cur_r + 16'd1 : cur_r - 16'd1;
            end else begin
                ramp_cnt_r <= ramp_cnt_r + 20'd1;
            end
            motor_speed_out <= cur_r;
            motor_dir_out <= dir_r;
            motor_run_out <= run_req & ~both_on;
            hard_stop_out <= both_on;
            edit_blink_out <= edit_pend_r;
            confirm_blink_out <= (conf_cnt_r != 28'h0000000);
            panel_disabled_out <= ext_only && (run_sw || flash_cnt_r != 28'h0000000);
            poweron_run_alarm_out <= alarm_r;
            set_sel_out <= set_sel;
        end
    end
endmodule // rcl_run_ctrl

// file: tb/rcl_run_ctrl_asserts.sv
// Checker for the run-command block: bus answer, ramp, stop and alarm relations
`timescale 1ns/1ps
module rcl_run_ctrl_asserts (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [15:0] motor_speed_out,
    input wire logic motor_dir_out,
    input wire logic motor_run_out,
    input wire logic hard_stop_out,
    input wire logic edit_blink_out,
    input wire logic confirm_blink_out,
    input wire logic poweron_run_alarm_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    a_bus_ready: assert property (
        psel_in && !penable_in |=> pready_out ##1 !pready_out)
        else $error("Ready is not a one-cycle answer");
    a_bus_unmapped: assert property (
        psel_in && !penable_in && paddr_in == 8'h14 |=> pslverr_out && pready_out)
        else $error("Unmapped address not refused");
    a_rdata_idle: assert property (
        !pready_out |-> prdata_out == 32'h0)
        else $error("Read data not zero outside access");
    a_dir_at_zero: assert property (
        $changed(motor_dir_out) |-> motor_speed_out == 16'h0 || $past(motor_speed_out) == 16'h0)
        else $error("Direction changed while turning");
    a_ramp_one_step: assert property (
        $changed(motor_speed_out) && !hard_stop_out && !$past(hard_stop_out)
        |-> motor_speed_out == $past(motor_speed_out) + 16'h1 || motor_speed_out == $past(motor_speed_out) - 16'h1)
        else $error("Speed jumped by more than one step");
    a_hard_stop_spd: assert property (
        hard_stop_out |-> ##[0:1] motor_speed_out == 16'h0)
        else $error("Hard stop did not zero the speed");
    a_hard_stop_run: assert property (
        hard_stop_out |-> !motor_run_out)
        else $error("Run request active during hard stop");
    a_alarm_blocks: assert property (
        poweron_run_alarm_out |-> !motor_run_out)
        else $error("Run request active under alarm");
    a_alarm_hold: assert property (
        poweron_run_alarm_out && !$past(psel_in && penable_in && pwrite_in && paddr_in == 8'h08)
        |=> poweron_run_alarm_out)
        else $error("Alarm cleared without a clear write");
    c_hard_stop: cover property (hard_stop_out);
    c_alarm: cover property ($rose(poweron_run_alarm_out));
    c_edit: cover property ($rose(edit_blink_out));
    c_confirm: cover property ($rose(confirm_blink_out));
endmodule // rcl_run_ctrl_asserts

bind rcl_run_ctrl rcl_run_ctrl_asserts chk (.core_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .prdata_out, .pready_out, .pslverr_out, .motor_speed_out, .motor_dir_out, .motor_run_out, .hard_stop_out,
    .edit_blink_out, .confirm_blink_out, .poweron_run_alarm_out);

// file: tb/rcl_ext_ctrl.sv
// External run controller model driving the isolated run and data-select inputs
`timescale 1ns/1ps
module rcl_ext_ctrl (
    input wire logic clk_in,
    input wire logic [1:0] run_req_in,
    input wire logic [1:0] sel_req_in,
    output logic fwd_out,
    output logic rev_out,
    output logic [1:0] sel_out
);
    initial begin
        fwd_out = 1'b0;
        rev_out = 1'b0;
        sel_out = 2'h0;
    end
    // Contacts change just after an edge and then stay as steady levels
    always @(posedge clk_in) begin
        fwd_out <= run_req_in[0];
        rev_out <= run_req_in[1];
        sel_out <= sel_req_in;
    end
endmodule // rcl_ext_ctrl

// file: tb/rcl_run_ctrl_test.sv
// Self-checking bench for the run-command block with an external controller model
`timescale 1ns/1ps
`include "rcl_regs.vh"
module rcl_run_ctrl_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] padr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic run_sw = 1'b1;
    logic dir_sw = 1'b0;
    logic da = 1'b0;
    logic db = 1'b0;
    logic push = 1'b0;
    logic [7:0] pot = 8'h00;
    logic [1:0] rq = 2'h0;
    logic [1:0] sq = 2'h0;
    logic [31:0] rd;
    logic er;
    wire [31:0] prd;
    wire prdy, perr, mdir, mrun, hstop, eblink, cblink, pdis, alarm, forward_run_input, reverse_run_input;
    wire [15:0] spd;
    wire [1:0] setsel, dsel;
    int failures = 0;
    int total_checks = 0;
    always #10 clk = ~clk;
    rcl_ext_ctrl ext (.clk_in(clk), .run_req_in(rq), .sel_req_in(sq), .fwd_out(forward_run_input), .rev_out(reverse_run_input), .sel_out(dsel));
    rcl_run_ctrl #(.DEB_CYC(20'd4), .FAST_CYC(28'd20), .FLASH_CYC(28'd50), .CONF_CYC(28'd30)) dut (
        .core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(padr),
        .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .run_switch_in(run_sw),
        .dir_switch_in(dir_sw), .dial_a_in(da), .dial_b_in(db), .dial_push_in(push), .forward_run_input_in(forward_run_input),
        .reverse_run_input_in(reverse_run_input), .data_select_low_in(dsel[0]), .data_select_high_in(dsel[1]), .ramp_pot_in(pot),
        .motor_speed_out(spd), .motor_dir_out(mdir), .motor_run_out(mrun), .hard_stop_out(hstop),
        .edit_blink_out(eblink), .confirm_blink_out(cblink), .panel_disabled_out(pdis),
        .poweron_run_alarm_out(alarm), .set_sel_out(setsel));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 16);
        if (prdy !== 1'b1) begin
            failures++;
            $display("[FAIL] pready expected 1 seen %b", prdy);
        end
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task wspd(input logic [15:0] v);
        int n;
        n = 0;
        while (spd !== v && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk("speed", v, spd);
    endtask
    // One detent: B sets the sense, then A rises
    task det(input logic cw, input int gap);
        db <= ~cw;
        wt(7);
        da <= 1'b1;
        wt(7);
        da <= 1'b0;
        wt(gap);
    endtask
    task press;
        push <= 1'b1;
        wt(8);
        push <= 1'b0;
        wt(8);
    endtask
    task t_boot;
        wt(20);
        chk("alarm", 1, alarm);
        chk("run", 0, mrun);
        apb(0, `RCL_OFF_CTRL, 0);
        chk("ctrl", 32'h8, rd);
        apb(0, `RCL_OFF_ACC0, 0);
        chk("acc0", 32'h100, rd);
        apb(0, 8'h14, 0);
        chk("err", 1, er);
        apb(1, `RCL_OFF_CTRL, 32'hB);
        apb(0, `RCL_OFF_CTRL, 0);
        chk("src3", 32'h8, rd);
        run_sw <= 1'b0;
        wt(10);
        apb(1, `RCL_OFF_ALMCLR, 1);
        wt(2);
        chk("alarm clr", 0, alarm);
        $display("test boot done");
    endtask
    task t_dial;
        apb(1, `RCL_OFF_SPD0, 32'd20);
        det(1, 40);
        apb(0, `RCL_OFF_EDIT, 0);
        chk("edit up", 32'd21, rd);
        chk("blink", 1, eblink);
        det(0, 40);
        det(0, 40);
        apb(0, `RCL_OFF_EDIT, 0);
        chk("edit down", 32'd19, rd);
        det(1, 0);
        det(1, 40);
        apb(0, `RCL_OFF_EDIT, 0);
        chk("edit fast", 32'd20 + `RCL_FAST_STEP, rd);
        apb(0, `RCL_OFF_SPD0, 0);
        chk("pending", 32'd20, rd);
        press;
        apb(0, `RCL_OFF_SPD0, 0);
        chk("commit", 32'd30, rd);
        chk("blink off", 0, eblink);
        press;
        chk("confirm", 1, cblink);
        apb(0, `RCL_OFF_SPD0, 0);
        chk("confirm keeps", 32'd30, rd);
        apb(1, `RCL_OFF_CTRL, 32'hC);
        det(1, 40);
        chk("locked", 0, eblink);
        apb(1, `RCL_OFF_CTRL, 32'h8);
        $display("test dial done");
    endtask
    task t_panel;
        run_sw <= 1'b1;
        wspd(16'd30);
        chk("run", 1, mrun);
        dir_sw <= 1'b1;
        wspd(16'd0);
        wspd(16'd30);
        chk("dir", 1, mdir);
        run_sw <= 1'b0;
        wspd(16'd0);
        dir_sw <= 1'b0;
        $display("test panel done");
    endtask
    task t_ext;
        int n;
        apb(1, `RCL_OFF_CTRL, 32'h9);
        for (int s = 1; s < 4; s++) apb(1, `RCL_OFF_SPD0 + 8'(4 * s), 32'(10 * s + 30));
        run_sw <= 1'b1;
        wt(12);
        chk("idle", 0, mrun);
        det(0, 40);
        apb(0, `RCL_OFF_EDIT, 0);
        chk("ext edit", 32'd29, rd);
        det(1, 40);
        press;
        chk("ext commit", 0, eblink);
        rq <= 2'b01;
        for (int s = 0; s < 4; s++) begin
            sq <= s[1:0];
            wspd(16'(10 * s + 30));
            chk("set", s, setsel);
        end
        chk("fwd dir", 0, mdir);
        apb(1, `RCL_OFF_DEC0 + 8'h08, 32'h1);
        apb(1, `RCL_OFF_CTRL, 32'h1);
        sq <= 2'h2;
        wspd(16'd55);
        n = 0;
        while (spd == 16'd55 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk("dec period", 17, n);
        apb(1, `RCL_OFF_CTRL, 32'h9);
        sq <= 2'h3;
        wspd(16'd60);
        rq <= 2'b11;
        wt(12);
        chk("hard", 1, hstop);
        chk("hard spd", 0, spd);
        rq <= 2'b10;
        wspd(16'd60);
        chk("rev dir", 1, mdir);
        run_sw <= 1'b0;
        wspd(16'd0);
        rq <= 2'b00;
        $display("test ext done");
    endtask
    task t_only;
        apb(1, `RCL_OFF_CTRL, 32'hA);
        run_sw <= 1'b1;
        wt(12);
        chk("pdis", 1, pdis);
        chk("no run", 0, mrun);
        dir_sw <= 1'b1;
        rq <= 2'b01;
        wspd(16'd60);
        chk("fixed dir", 0, mdir);
        run_sw <= 1'b0;
        wt(10);
        dir_sw <= 1'b0;
        wt(20);
        chk("pdis timed", 1, pdis);
        chk("sw ignored", 1, mrun);
        wt(60);
        chk("pdis end", 0, pdis);
        rq <= 2'b00;
        wspd(16'd0);
        $display("test ext only done");
    endtask
    task report_and_stop;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        wt(8);
        rst <= 1'b0;
        t_boot;
        t_dial;
        t_panel;
        t_ext;
        t_only;
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop;
    end
endmodule // rcl_run_ctrl_test
